// File: hdl/uec_pkg.sv
// Constants for the endpoint command port
package uec_pkg;

    // Register byte offsets
    localparam int         ADDR_W    = 8;
    localparam logic [7:0] OFF_CMD   = 8'h00;
    localparam logic [7:0] OFF_BRQ   = 8'h04;
    localparam logic [7:0] OFF_ISTAT = 8'h08;
    localparam logic [7:0] OFF_ICLR  = 8'h0c;
    localparam logic [7:0] OFF_IEN   = 8'h10;

    // Command register fields
    localparam int CMD_CODE_LSB   = 0;
    localparam int CMD_EP_LSB     = 4;
    localparam int CMD_NULEP_LSB  = 8;
    localparam int CMD_TOGGLE_BIT = 15;

    // Values after reset
    localparam logic [3:0]  CODE_RST   = 4'h0;
    localparam logic [3:0]  EP_RST     = 4'h0;
    localparam logic [15:0] BRQ_RST    = 16'h0000;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

    // Command codes
    localparam logic [3:0] CMD_RSVD0      = 4'h0;
    localparam logic [3:0] CMD_SETUP_DONE = 4'h1;
    localparam logic [3:0] CMD_FORCE_EVEN = 4'h2;
    localparam logic [3:0] CMD_EP_CLEAR   = 4'h3;
    localparam logic [3:0] CMD_EP_HALT    = 4'h4;
    localparam logic [3:0] CMD_EP_UNUSE   = 4'h5;
    localparam logic [3:0] CMD_RSVD6      = 4'h6;
    localparam logic [3:0] CMD_EP_OFF     = 4'h7;
    localparam logic [3:0] CMD_EP_ON      = 4'h8;
    localparam logic [3:0] CMD_ALL_UNUSE  = 4'h9;
    localparam logic [3:0] CMD_BUS_READY  = 4'ha;
    localparam logic [3:0] CMD_SETUP_RCVD = 4'hb;
    localparam logic [3:0] CMD_SHORT_END  = 4'hc;
    localparam logic [3:0] CMD_BUF_FLUSH  = 4'hd;
    localparam logic [3:0] CMD_SEND_NULL  = 4'he;
    localparam logic [3:0] CMD_RSVDF      = 4'hf;

    // Interrupt status bits
    localparam int IRQ_W      = 3;
    localparam int IRQ_NULL   = 0;
    localparam int IRQ_SETUP  = 1;
    localparam int IRQ_BADCMD = 2;
    localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

endpackage

// File: hdl/uec_cmd_decode.sv
// Command code decoder: one-hot strobe and reserved-code detection
`timescale 1ns/100ps
module uec_cmd_decode
    import uec_pkg::*;
(
    // Code in
    input  wire logic [3:0]  code,
    // Decoded
    output logic      [15:0] oneHot,
    output logic             isReserved
);

    always_comb begin
        isReserved = (code == CMD_RSVD0) || (code == CMD_RSVD6) || (code == CMD_RSVDF);
        oneHot     = 16'h0000;
        if (!isReserved) begin
            oneHot[code] = 1'b1;
        end
    end

endmodule

// File: hdl/uec_setup_capture.sv
// Capture of request type and request bytes of a setup packet
`timescale 1ns/100ps
module uec_setup_capture
    import uec_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // Setup bytes from the packet engine
    input  wire logic        setupValid,
    input  wire logic [7:0]  setupByte0,
    input  wire logic [7:0]  setupByte1,
    // Captured fields
    output logic      [15:0] brqValue,
    output logic             captured
);

    logic [15:0] brq_r;
    logic        cap_r;

    // Byte 1 in [15:8]; byte 0 holds direction, category, addressee
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            brq_r <= BRQ_RST;
        end else if (setupValid) begin
            brq_r <= {setupByte1, setupByte0};
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cap_r <= 1'b0;
        end else begin
            cap_r <= setupValid;
        end
    end

    assign brqValue = brq_r;
    assign captured = cap_r;

endmodule

// File: hdl/uec_endpoint_command.sv
// Endpoint command port with request capture and event interrupts
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps

// How it works
// - Bit 15 set: advance PID without handshake
// - Bits 11-8 show last null-packet endpoint
// - That endpoint holds until next null packet
// - Each null packet overwrites the endpoint field
// - Codes 1-5 and 7-8 decode; 0, 6, F reserved
// - Codes 9-E decode, change no endpoint state
// - Second setup byte lands in bits 15-8
// - Bit 7 gives control transfer direction
// - Bits 4-0 give request addressee
module uec_endpoint_command
    import uec_pkg::*;
#(
    parameter int NUM_EP = 16
)(
    // Clock and reset
    input  wire logic              core_clk,
    input  wire logic              nrst,
    // Register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [31:0]       regWdata,
    input  wire logic              regWrite,
    input  wire logic              regRead,
    output logic      [31:0]       regRdata,
    // Packet engine events
    input  wire logic              nullRxValid,
    input  wire logic [3:0]        nullRxEndpoint,
    input  wire logic              setupValid,
    input  wire logic [7:0]        setupByte0,
    input  wire logic [7:0]        setupByte1,
    input  wire logic              intInAck,
    input  wire logic              intInNoAck,
    input  wire logic [3:0]        intInEndpoint,
    // Command issue
    output logic                   cmdValid,
    output logic      [3:0]        cmdCode,
    output logic      [3:0]        cmdEndpoint,
    output logic      [15:0]       cmdOneHot,
    // Endpoint state
    output logic      [NUM_EP-1:0] epOn,
    output logic      [NUM_EP-1:0] epHalt,
    output logic      [NUM_EP-1:0] epPidOdd,
    // Interrupt
    output logic                   irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Parameter check

    if (NUM_EP < 1 || NUM_EP > 16) begin : gBadNumEp
        $error("NUM_EP must lie in 1..16");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic epIs(input logic [3:0] ep, input int idx);
        epIs = (ep == 4'(idx));
    endfunction

    function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] off);
        regHit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic                 toggle_r;
    logic [3:0]           ep_r;
    logic [3:0]           code_r;
    logic [3:0]           nulEp_r;
    logic                 cmdValid_r;
    logic [3:0]           cmdCode_r;
    logic [3:0]           cmdEp_r;
    logic [15:0]          cmdOneHot_r;
    logic [NUM_EP-1:0]    epOn_r;
    logic [NUM_EP-1:0]    epHalt_r;
    logic [NUM_EP-1:0]    epPid_r;
    logic [IRQ_W-1:0]     istat_r;
    logic [IRQ_W-1:0]     ien_r;
    logic [31:0]          rdata_r;
    logic [31:0]          rdata_nxt;
    logic [IRQ_W-1:0]     events;
    logic [15:0]          brqValue;
    logic                 setupSeen;
    logic                 wrCmd;
    logic [3:0]           wrCode;
    logic [3:0]           wrEp;
    logic [15:0]          decOneHot;
    logic                 decReserved;
    logic                 fire;

    ////////////////////////////////////////////////////////////////////////////
    // Command write decode

    assign wrCmd  = regWrite && regHit(regAddr, OFF_CMD);
    assign wrCode = regWdata[CMD_CODE_LSB +: 4];
    assign wrEp   = regWdata[CMD_EP_LSB +: 4];

    uec_cmd_decode uDecode (
        .code       (wrCode),
        .oneHot     (decOneHot),
        .isReserved (decReserved)
    );

    // Only a write carries a command, so a held code never repeats
    assign fire = wrCmd && !decReserved;

    ////////////////////////////////////////////////////////////////////////////
    // Command register fields

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            toggle_r <= 1'b0;
            ep_r     <= EP_RST;
            code_r   <= CODE_RST;
        end else if (wrCmd) begin
            toggle_r <= regWdata[CMD_TOGGLE_BIT];
            ep_r     <= wrEp;
            code_r   <= wrCode;
        end
    end

    // Null-packet endpoint: last arrival wins, else held
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            nulEp_r <= EP_RST;
        end else if (nullRxValid) begin
            nulEp_r <= nullRxEndpoint;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command issue, one pulse per accepted write

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cmdValid_r  <= 1'b0;
            cmdCode_r   <= CODE_RST;
            cmdEp_r     <= EP_RST;
            cmdOneHot_r <= 16'h0000;
        end else begin
            cmdValid_r  <= fire;
            cmdOneHot_r <= fire ? decOneHot : 16'h0000;
            if (fire) begin
                cmdCode_r <= wrCode;
                cmdEp_r   <= wrEp;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Endpoint on/off and halt state

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            epOn_r   <= '0;
            epHalt_r <= '0;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                if (fire && epIs(wrEp, i)) begin
                    case (wrCode)
                        CMD_EP_ON: begin
                            epOn_r[i] <= 1'b1;
                        end
                        CMD_EP_OFF: begin
                            epOn_r[i] <= 1'b0;
                        end
                        CMD_EP_HALT: begin
                            epHalt_r[i] <= 1'b1;
                        end
                        CMD_EP_CLEAR: begin
                            epHalt_r[i] <= 1'b0;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Data PID per endpoint

    // A clearing command outranks a toggle in the same cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            epPid_r <= '0;
        end else begin
            for (int i = 0; i < NUM_EP; i++) begin
                if (fire && epIs(wrEp, i) &&
                    (wrCode == CMD_FORCE_EVEN || wrCode == CMD_EP_CLEAR)) begin
                    epPid_r[i] <= 1'b0;
                end else if (intInAck && epIs(intInEndpoint, i)) begin
                    epPid_r[i] <= ~epPid_r[i];
                end else if (intInNoAck && epIs(intInEndpoint, i) && toggle_r) begin
                    epPid_r[i] <= ~epPid_r[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Setup request capture

    uec_setup_capture uCapture (
        .core_clk   (core_clk),
        .nrst       (nrst),
        .setupValid (setupValid),
        .setupByte0 (setupByte0),
        .setupByte1 (setupByte1),
        .brqValue   (brqValue),
        .captured   (setupSeen)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status, clear and enable

    always_comb begin
        events             = '0;
        events[IRQ_NULL]   = nullRxValid;
        events[IRQ_SETUP]  = setupSeen;
        events[IRQ_BADCMD] = wrCmd && decReserved;
    end

    // A new event wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            istat_r <= IRQ_RST;
        end else if (regWrite && regHit(regAddr, OFF_ICLR)) begin
            istat_r <= (istat_r & ~regWdata[IRQ_W-1:0]) | events;
        end else begin
            istat_r <= istat_r | events;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ien_r <= IRQ_RST;
        end else if (regWrite && regHit(regAddr, OFF_IEN)) begin
            ien_r <= regWdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path, data one cycle after the strobe

    // Unused bits and unmapped offsets read as zero
    always_comb begin
        rdata_nxt = RDATA_RST;
        if (regRead) begin
            case (regAddr)
                OFF_CMD: begin
                    rdata_nxt[CMD_TOGGLE_BIT]       = toggle_r;
                    rdata_nxt[CMD_NULEP_LSB +: 4]   = nulEp_r;
                    rdata_nxt[CMD_EP_LSB +: 4]      = ep_r;
                    rdata_nxt[CMD_CODE_LSB +: 4]    = code_r;
                end
                OFF_BRQ: begin
                    rdata_nxt[15:0] = brqValue;
                end
                OFF_ISTAT: begin
                    rdata_nxt[IRQ_W-1:0] = istat_r;
                end
                OFF_IEN: begin
                    rdata_nxt[IRQ_W-1:0] = ien_r;
                end
                default: begin
                    rdata_nxt = RDATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign regRdata    = rdata_r;
    assign cmdValid    = cmdValid_r;
    assign cmdCode     = cmdCode_r;
    assign cmdEndpoint = cmdEp_r;
    assign cmdOneHot   = cmdOneHot_r;
    assign epOn        = epOn_r;
    assign epHalt      = epHalt_r;
    assign epPidOdd    = epPid_r;
    assign irq         = |(istat_r & ien_r);

endmodule

// File: testbench/uec_endpoint_command_monitor.sv
// Checker for the endpoint command port
`timescale 1ns/100ps
module uec_endpoint_command_monitor
    import uec_pkg::*;
#(
    parameter int NUM_EP = 16
)(
    // Clock and reset
    input wire logic              core_clk,
    input wire logic              nrst,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [31:0]       regWdata,
    input wire logic              regWrite,
    input wire logic              regRead,
    input wire logic [31:0]       regRdata,
    // Events
    input wire logic              nullRxValid,
    input wire logic [3:0]        nullRxEndpoint,
    input wire logic              setupValid,
    input wire logic [7:0]        setupByte0,
    input wire logic [7:0]        setupByte1,
    input wire logic              intInNoAck,
    input wire logic [3:0]        intInEndpoint,
    // Results
    input wire logic              cmdValid,
    input wire logic [3:0]        cmdCode,
    input wire logic [3:0]        cmdEndpoint,
    input wire logic [15:0]       cmdOneHot,
    input wire logic [NUM_EP-1:0] epPidOdd,
    input wire logic              irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    logic      togR;
    wire logic cmdW = regWrite && regAddr == OFF_CMD;
    wire logic rsvd = regWdata[3:0] inside {CMD_RSVD0, CMD_RSVD6, CMD_RSVDF};
    wire logic rdCmd = regRead && regAddr == OFF_CMD;
    wire logic rdBrq = regRead && regAddr == OFF_BRQ;
    wire logic ienOff = regWrite && regAddr == OFF_IEN && regWdata[2:0] == 3'h0;

    // Shadow of the toggle policy bit
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst)
            togR <= 1'b0;
        else if (cmdW)
            togR <= regWdata[CMD_TOGGLE_BIT];
    end

    sequence s_cmdGood;
        cmdW && !rsvd;
    endsequence
    sequence s_nulRead;
        nullRxValid ##1 !nullRxValid ##1 rdCmd;
    endsequence
    sequence s_setupRead;
        setupValid ##1 !setupValid ##1 rdBrq;
    endsequence

    a_cmd_issue: assert property (s_cmdGood |=> cmdValid && cmdOneHot == (16'h1 << cmdCode))
        else $error("command strobe or one-hot wrong");
    a_cmd_fields: assert property (s_cmdGood |=> cmdCode == $past(regWdata[3:0])
        && cmdEndpoint == $past(regWdata[7:4]))
        else $error("issued code or endpoint wrong");
    a_rsvd_quiet: assert property (cmdW && rsvd |=> !cmdValid)
        else $error("reserved code issued");
    a_no_spurious: assert property (!cmdW |=> !cmdValid && cmdOneHot == 16'h0)
        else $error("command issued without write");
    a_nul_field: assert property (s_nulRead |=> regRdata[11:8] == $past(nullRxEndpoint, 3))
        else $error("null endpoint field wrong");
    a_nul_hold: assert property (rdCmd && !nullRxValid ##1 !nullRxValid ##1 rdCmd |=>
        regRdata[11:8] == $past(regRdata[11:8], 2))
        else $error("null endpoint field changed");
    a_pid_noack: assert property (intInNoAck && !regWrite && !cmdValid |=>
        (epPidOdd ^ $past(epPidOdd)) == (NUM_EP'(togR) << $past(intInEndpoint)))
        else $error("pid toggle policy broken");
    a_brq_capture: assert property (s_setupRead |=>
        regRdata[15:0] == {$past(setupByte1, 3), $past(setupByte0, 3)})
        else $error("request capture wrong");
    a_irq_off: assert property (ienOff ##1 !(regWrite && regAddr == OFF_IEN) |=> !irq)
        else $error("interrupt while all disabled");
endmodule

bind uec_endpoint_command uec_endpoint_command_monitor #(.NUM_EP(NUM_EP)) mon (.core_clk, .nrst,
    .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .nullRxValid, .nullRxEndpoint,
    .setupValid, .setupByte0, .setupByte1, .intInNoAck, .intInEndpoint, .cmdValid, .cmdCode,
    .cmdEndpoint, .cmdOneHot, .epPidOdd, .irq);

// File: testbench/uec_host_model.sv
// Packet engine events as the host side causes them
`timescale 1ns/100ps
module uec_host_model (
    // Clock
    input  wire logic core_clk,
    // Events
    output logic       nullRxValid,
    output logic [3:0] nullRxEndpoint,
    output logic       setupValid,
    output logic [7:0] setupByte0,
    output logic [7:0] setupByte1,
    output logic       intInAck,
    output logic       intInNoAck,
    output logic [3:0] intInEndpoint
);
    initial begin
        {nullRxValid, setupValid, intInAck, intInNoAck} = 4'h0;
        {nullRxEndpoint, setupByte0, setupByte1, intInEndpoint} = 24'h0;
    end

    // One-cycle pulses; released data lines show the inverse value
    task automatic nullPkt(input logic [3:0] e);
        nullRxValid <= 1'b1;
        nullRxEndpoint <= e;
        @(posedge core_clk);
        nullRxValid <= 1'b0;
        nullRxEndpoint <= ~e;
        @(posedge core_clk);
    endtask
    task automatic setupPkt(input logic [7:0] b0, input logic [7:0] b1);
        setupValid <= 1'b1;
        {setupByte1, setupByte0} <= {b1, b0};
        @(posedge core_clk);
        setupValid <= 1'b0;
        {setupByte1, setupByte0} <= ~{b1, b0};
        @(posedge core_clk);
    endtask
    task automatic intIn(input logic ack, input logic [3:0] e);
        {intInAck, intInNoAck} <= {ack, !ack};
        intInEndpoint <= e;
        @(posedge core_clk);
        {intInAck, intInNoAck} <= 2'h0;
        intInEndpoint <= ~e;
        @(posedge core_clk);
    endtask
endmodule

// File: testbench/uec_endpoint_command_test.sv
// Self-checking bench for the endpoint command port
`timescale 1ns/100ps
module uec_endpoint_command_test
    import uec_pkg::*;
;
    logic              core_clk = 1'b0;
    logic              nrst = 1'b0;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [31:0]       regWdata = '0;
    logic              regWrite = 1'b0;
    logic              regRead = 1'b0;
    logic [31:0]       regRdata, rd;
    logic              nullRxValid, setupValid, intInAck, intInNoAck, cmdValid, irq;
    logic [3:0]        nullRxEndpoint, intInEndpoint, cmdCode, cmdEndpoint, e;
    logic [7:0]        setupByte0, setupByte1;
    logic [7:0]        reqType, reqCode;
    logic [15:0]       cmdOneHot, epOn, epHalt, epPidOdd;
    logic [15:0]       expOn = '0, expHalt = '0, expPid = '0;
    logic [3:0]        expNul = '0, expEp = '0, expCode = '0, lastC = '0, lastE = '0;
    logic              expTog = 1'b0;
    logic [24:0]       pulse;
    int                fail_count = 0;
    int                checks = 0;

    always #2.5 core_clk = ~core_clk;

    uec_endpoint_command #(.NUM_EP(16)) dut (.core_clk, .nrst, .regAddr, .regWdata, .regWrite,
        .regRead, .regRdata, .nullRxValid, .nullRxEndpoint, .setupValid, .setupByte0,
        .setupByte1, .intInAck, .intInNoAck, .intInEndpoint, .cmdValid, .cmdCode,
        .cmdEndpoint, .cmdOneHot, .epOn, .epHalt, .epPidOdd, .irq);
    uec_host_model host (.core_clk, .nullRxValid, .nullRxEndpoint, .setupValid, .setupByte0,
        .setupByte1, .intInAck, .intInNoAck, .intInEndpoint);

    ////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic regWr(input logic [7:0] a, input logic [31:0] d);
        {regWrite, regAddr, regWdata} <= {1'b1, a, d};
        @(posedge core_clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
        #1 pulse = {cmdValid, cmdOneHot, cmdCode, cmdEndpoint};
        @(posedge core_clk);
    endtask
    task automatic regRd(input logic [7:0] a);
        {regRead, regAddr} <= {1'b1, a};
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 rd = regRdata;
        @(posedge core_clk);
    endtask
    function automatic logic [31:0] cmdWord();
        return {16'h0, expTog, 3'h0, expNul, expEp, expCode};
    endfunction
    function automatic void applyCmd(input logic [3:0] c, input logic [3:0] n);
        case (c)
            CMD_FORCE_EVEN: expPid[n] = 1'b0;
            CMD_EP_CLEAR: {expHalt[n], expPid[n]} = 2'h0;
            CMD_EP_HALT: expHalt[n] = 1'b1;
            CMD_EP_OFF: expOn[n] = 1'b0;
            CMD_EP_ON: expOn[n] = 1'b1;
            default: ;
        endcase
    endfunction
    task automatic cmd(input logic t, input logic [3:0] n, input logic [3:0] c);
        logic rsv;
        rsv = c inside {CMD_RSVD0, CMD_RSVD6, CMD_RSVDF};
        regWr(OFF_CMD, {16'($urandom), t, 7'($urandom), n, c});
        chk(pulse, rsv ? {17'h0, lastC, lastE} : {1'b1, 16'h1 << c, c, n});
        {expTog, expEp, expCode} = {t, n, c};
        if (!rsv) begin
            {lastC, lastE} = {c, n};
            applyCmd(c, n);
        end
        chk({epOn, epHalt, epPidOdd}, {expOn, expHalt, expPid});
        regRd(OFF_CMD);
        chk(rd, cmdWord());
    endtask

    ////////////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h84538102));
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        regRd(OFF_CMD);
        chk(rd, 32'h0);
        regRd(OFF_BRQ);
        chk(rd, 32'h0);
        regRd(8'h20);
        chk(rd, 32'h0);
        regWr(OFF_IEN, 32'h7);
        // Every code once, then random codes
        for (int i = 0; i < 48; i++)
            cmd(1'($urandom), 4'($urandom), (i < 16) ? i[3:0] : 4'($urandom));
        repeat (5) begin
            e = 4'($urandom);
            host.nullPkt(e);
            expNul = e;
            regRd(OFF_CMD);
            chk(rd, cmdWord());
        end
        regRd(OFF_CMD);
        chk(rd, cmdWord());
        cmd(1'b1, 4'h3, CMD_EP_ON);
        // Toggle policy without handshake, both settings
        for (int t = 0; t < 2; t++) begin
            cmd(t[0], e, CMD_FORCE_EVEN);
            host.intIn(1'b0, e);
            expPid[e] ^= t[0];
            chk(epPidOdd, expPid);
            host.intIn(1'b1, e);
            expPid[e] ^= 1'b1;
            chk(epPidOdd, expPid);
        end
        // Direction, category and addressee combinations
        for (int i = 0; i < 8; i++) begin
            reqType = {i[2:0], 5'(i)};
            reqCode = 8'($urandom);
            host.setupPkt(reqType, reqCode);
            regRd(OFF_BRQ);
            chk(rd, {16'h0, reqCode, reqType});
        end
        regWr(OFF_ISTAT, 32'h0);
        regRd(OFF_ISTAT);
        chk({irq, rd}, {1'b1, 32'h7});
        regWr(OFF_ICLR, 32'h5);
        regWr(OFF_IEN, 32'h1);
        regRd(OFF_ISTAT);
        chk({irq, rd}, {1'b0, 32'h2});
        host.nullPkt(4'h9);
        regRd(OFF_ISTAT);
        chk({irq, rd}, {1'b1, 32'h3});
        regWr(OFF_ICLR, 32'h7);
        regRd(OFF_IEN);
        chk({irq, rd}, {1'b0, 32'h1});
        regWr(OFF_IEN, 32'h0);
        host.nullPkt(4'h1);
        chk(irq, 1'b0);
        // Second reset in mid-run
        nrst <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        regRd(OFF_CMD);
        chk({rd, epOn, epHalt}, 64'h0);
        complete_run();
    end
endmodule
